// [rtl/psr_top.sv]
// Status outputs, reconfiguration port and register slave of the endpoint sideband
`timescale 1ns/100ps
`default_nettype none

module psr_top #(
    parameter int CLEAR_COUNT = psr_pkg::CLEAR_CYCLES // Reset sweep length
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic warm_rst_in,
    // Core-side events and status
    input wire logic [3:0] ecc_evt_in,
    input wire logic [3:0] intx_in,
    input wire logic [3:0] fn1_intx_in,
    input wire logic [3:0] fn1_other_in,
    input wire logic root_adv_err_msg_req_in,
    input wire logic root_adv_err_wire_req_in,
    input wire logic pme_msg_req_in,
    input wire logic pme_wire_req_in,
    input wire logic hot_plug_in,
    input wire logic bw_auto_in,
    input wire logic bw_mgmt_in,
    input wire logic link_eq_req_in,
    input wire logic [4:0] lane_count_in,
    input wire logic link_up_in,
    input wire logic [5:0] ltssm_in,
    input wire logic rx_par_det_in,
    input wire logic tx_par_det_in,
    // Status toward the application
    output logic [3:0] ecc_err_out,
    output logic [10:0] int_status_out,
    output logic [7:0] irq_state_vec_fn1_out,
    output logic [2:0] int_common_out,
    output logic [4:0] lane_act_out,
    output logic link_up_out,
    output logic [5:0] ltssm_out,
    output logic rx_par_err_out,
    output logic tx_par_err_out,
    // Reconfiguration port
    input wire logic [psr_pkg::RCFG_AW-1:0] rcfg_addr_in,
    input wire logic rcfg_read_in,
    input wire logic rcfg_write_in,
    input wire logic [7:0] rcfg_wdata_in,
    output logic [7:0] rcfg_rdata_out,
    output logic rcfg_rvalid_out,
    output logic rcfg_wait_out,
    // AXI4-Lite register slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import psr_pkg::*;

    // Binary lane count to one-hot width code
    function automatic logic [4:0] lanes_onehot(input logic [4:0] n);
        unique case (n)
            5'h01: lanes_onehot = 5'h01;
            5'h02: lanes_onehot = 5'h02;
            5'h04: lanes_onehot = 5'h04;
            5'h08: lanes_onehot = 5'h08;
            5'h10: lanes_onehot = 5'h10;
            default: lanes_onehot = 5'h00; // Untrained or illegal width
        endcase
    endfunction

    logic [1:0] ctrl; // Software control: PME enable, four-function mode
    logic [5:0] err_log; // Sticky error log
    logic [5:0] err_set; // Error events this cycle, in log bit order
    logic aer_wire_d; // Previous wire request levels
    logic pme_wire_d;
    logic rx_det_d; // Previous parity detect levels
    logic tx_det_d;
    logic [7:0] aw_addr; // Captured write address
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb;
    logic do_write; // Both halves held, response not yet out
    logic wr_lo; // Byte 0 written this cycle
    logic irq_w1c_aer;
    logic irq_w1c_pme;
    logic four_fn;

    assign four_fn = ctrl[CTRL_FOUR_FN];
    assign do_write = !s_awready && !s_wready && !s_bvalid;
    assign wr_lo = do_write && w_strb[0];
    assign irq_w1c_aer = wr_lo && aw_addr == OFS_IRQ && w_data[IRQ_AER];
    assign irq_w1c_pme = wr_lo && aw_addr == OFS_IRQ && w_data[IRQ_PME];
    // Parity edges in bits 0 and 1, ECC events above them
    assign err_set = {ecc_evt_in, tx_par_det_in && !tx_det_d, rx_par_det_in && !rx_det_d};

    // ECC flags: receive-buffer then retry-buffer, single then double
    psr_stretch u_stretch (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pulse_in(ecc_evt_in),
        .stretched_out(ecc_err_out)
    );

    // Edge history for clears on deassertion and single-cycle pulses
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            aer_wire_d <= 1'b0;
            pme_wire_d <= 1'b0;
            rx_det_d <= 1'b0;
            tx_det_d <= 1'b0;
        end else begin
            aer_wire_d <= root_adv_err_wire_req_in;
            pme_wire_d <= pme_wire_req_in;
            rx_det_d <= rx_par_det_in;
            tx_det_d <= tx_par_det_in;
        end
    end

    // Interrupt status for function 0; set beats clear on bits 4 and 5
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            int_status_out <= 11'h000;
        end else begin
            int_status_out[3:0] <= intx_in;
            if (root_adv_err_msg_req_in || (root_adv_err_wire_req_in && !aer_wire_d)) begin
                int_status_out[IRQ_AER] <= 1'b1;
            end else if (irq_w1c_aer || (!root_adv_err_wire_req_in && aer_wire_d)) begin
                int_status_out[IRQ_AER] <= 1'b0;
            end
            if (pme_msg_req_in || (pme_wire_req_in && !pme_wire_d)) begin
                int_status_out[IRQ_PME] <= 1'b1;
            end else if (irq_w1c_pme || (!pme_wire_req_in && pme_wire_d)) begin
                int_status_out[IRQ_PME] <= 1'b0;
            end
            int_status_out[6] <= hot_plug_in && ctrl[CTRL_PME_EN];
            int_status_out[7] <= hot_plug_in;
            // Upper bits exist only in the four-function variant
            int_status_out[10:8] <= four_fn ? {link_eq_req_in, bw_mgmt_in, bw_auto_in}
                                            : 3'h0;
        end
    end

    // Second function's vector, live only in two-function mode
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            irq_state_vec_fn1_out <= 8'h00;
        end else begin
            irq_state_vec_fn1_out <= four_fn ? 8'h00
                                             : {fn1_other_in, fn1_intx_in};
        end
    end

    // Common pending bits and link status
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            int_common_out <= 3'h0;
            lane_act_out <= 5'h00;
            link_up_out <= 1'b0;
            ltssm_out <= 6'h00;
        end else begin
            int_common_out <= {link_eq_req_in, bw_mgmt_in, bw_auto_in};
            lane_act_out <= lanes_onehot(lane_count_in);
            link_up_out <= link_up_in;
            ltssm_out <= ltssm_in;
        end
    end

    // Parity pulses last one cycle even if the detect level is held
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rx_par_err_out <= 1'b0;
            tx_par_err_out <= 1'b0;
        end else begin
            rx_par_err_out <= rx_par_det_in && !rx_det_d;
            tx_par_err_out <= tx_par_det_in && !tx_det_d;
        end
    end

    // Error log: parity edges and all four ECC events kept until software clears them
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            err_log <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (err_set[i]) begin
                    err_log[i] <= 1'b1;
                end else if (wr_lo && aw_addr == OFS_ERRLOG && w_data[i]) begin
                    err_log[i] <= 1'b0;
                end
            end
        end
    end

    // Control register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctrl <= CTRL_RESET;
        end else if (wr_lo && aw_addr == OFS_CTRL) begin
            ctrl <= w_data[1:0];
        end
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                s_awready <= 1'b0;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                s_wready <= 1'b0;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp <= (aw_addr == OFS_CTRL || aw_addr == OFS_IRQ || aw_addr == OFS_FN1 ||
                            aw_addr == OFS_LINK || aw_addr == OFS_ERRLOG) ? RESP_OKAY
                                                                          : RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // Read channel: one answer per address, data decoded at the handshake
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            unique case (s_araddr)
                OFS_CTRL: s_rdata <= {30'h0, ctrl};
                OFS_IRQ: s_rdata <= {21'h0, int_status_out};
                OFS_FN1: s_rdata <= {24'h0, irq_state_vec_fn1_out};
                OFS_LINK: s_rdata <= {18'h0, ltssm_out, 2'h0, link_up_out, lane_act_out};
                OFS_ERRLOG: s_rdata <= {26'h0, err_log};
                default: begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= RESP_SLVERR; // Unmapped address
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // Reconfiguration port
    logic clr_active; // Sweep restoring defaults in progress
    logic [MEM_AW-1:0] clr_addr;
    logic rd_v0; // Read pipeline valids
    logic rd_v1;
    logic rd_sel0; // Read targeted configuration space
    logic rd_sel1;
    logic [7:0] rd_d1;
    logic [7:0] mem_rdata;
    logic rd_take;
    logic wr_take;
    logic cfg_space;
    logic [MEM_AW-1:0] cfg_idx;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;

    assign cfg_space = rcfg_addr_in[SPACE_SEL_BIT];
    // Function number sits on 13:12, or only on bit 12 with two functions
    assign cfg_idx = four_fn ? rcfg_addr_in[MEM_AW-1:0]
                             : {1'b0, rcfg_addr_in[MEM_AW-2:0]};
    assign rd_take = rcfg_read_in && !rcfg_wait_out;
    // A read in the same cycle wins; the write must be offered again
    assign wr_take = rcfg_write_in && !rcfg_read_in && !rcfg_wait_out && cfg_space;
    assign mem_we = clr_active || wr_take;
    assign mem_waddr = clr_active ? clr_addr : cfg_idx;
    assign mem_wdata = clr_active ? 8'h00 : rcfg_wdata_in;

    psr_cfg_mem u_mem (
        .clk_in(clk_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(cfg_idx),
        .rdata_out(mem_rdata)
    );

    // Any reset, cold or warm, sweeps the first CLEAR_COUNT bytes back to their default
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            clr_active <= 1'b1;
            clr_addr <= '0;
        end else if (warm_rst_in) begin
            clr_active <= 1'b1;
            clr_addr <= '0;
        end else if (clr_active) begin
            clr_addr <= clr_addr + 1'b1;
            if (clr_addr == MEM_AW'(CLEAR_COUNT - 1)) begin
                clr_active <= 1'b0;
            end
        end
    end

    // Three-stage read: memory register, hold stage, output register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rd_v0 <= 1'b0;
            rd_v1 <= 1'b0;
            rd_sel0 <= 1'b0;
            rd_sel1 <= 1'b0;
            rd_d1 <= 8'h00;
            rcfg_rdata_out <= 8'h00;
            rcfg_rvalid_out <= 1'b0;
        end else begin
            rd_v0 <= rd_take;
            rd_sel0 <= cfg_space;
            rd_v1 <= rd_v0;
            rd_sel1 <= rd_sel0;
            rd_d1 <= mem_rdata;
            rcfg_rvalid_out <= rd_v1;
            rcfg_rdata_out <= (rd_v1 && rd_sel1) ? rd_d1 : 8'h00; // Other spaces read zero
        end
    end

    // Busy during reset, the sweep and an outstanding read
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rcfg_wait_out <= 1'b1;
        end else begin
            rcfg_wait_out <= warm_rst_in || (clr_active && clr_addr != MEM_AW'(CLEAR_COUNT - 1))
                             || rd_take || rd_v0;
        end
    end

    chk_rx_par_single: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rx_par_err_out |=> !rx_par_err_out && err_log[ERR_RX_PAR])
        else $error("receive parity pulse too long or not logged");
    chk_tx_par_single: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_par_err_out |=> !tx_par_err_out)
        else $error("transmit parity pulse too long");
    chk_rd_third_cycle: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_take |-> !rcfg_rvalid_out ##1 !rcfg_rvalid_out ##1 !rcfg_rvalid_out ##1 rcfg_rvalid_out)
        else $error("read data not on third cycle");
    chk_rd_wait_busy: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_take |=> rcfg_wait_out [*2])
        else $error("wait-request low during read");
    chk_aer_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
        root_adv_err_msg_req_in |=> int_status_out[IRQ_AER])
        else $error("root error status not set");
    chk_pme_drop_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ($fell(pme_wire_req_in) && !pme_msg_req_in) |=> !int_status_out[IRQ_PME])
        else $error("power event status not cleared");
    chk_lane_onehot: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $onehot0(lane_act_out))
        else $error("lane code not one-hot");
    chk_two_fn_upper: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !four_fn && !$past(four_fn) |-> int_status_out[10:8] == 3'h0)
        else $error("upper status bits live in two-function mode");
    chk_warm_sweep: assert property (@(posedge clk_in) disable iff (!nrst_in)
        warm_rst_in |=> clr_active && rcfg_wait_out && clr_addr == '0)
        else $error("warm reset did not restart sweep");
endmodule
`default_nettype wire

// [rtl/psr_pkg.sv]
// Shared constants for the status and reconfiguration port block
package psr_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STRETCH_NS = 160;
    localparam int STRETCH_CYC = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LATENCY = 3;
    localparam int CLEAR_CYCLES = 16384;
    // Reconfiguration port geometry
    localparam int RCFG_AW = 21;
    localparam int MEM_AW = 14;
    localparam int SPACE_SEL_BIT = 20;
    // Training state codes
    localparam logic [5:0] LTSSM_L0 = 6'h11;
    localparam logic [5:0] LTSSM_HOT_RESET = 6'h1f;
    // Register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ = 8'h04;
    localparam logic [7:0] OFS_FN1 = 8'h08;
    localparam logic [7:0] OFS_LINK = 8'h0c;
    localparam logic [7:0] OFS_ERRLOG = 8'h10;
    // Control fields and reset values
    localparam int CTRL_PME_EN = 0;
    localparam int CTRL_FOUR_FN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    // Interrupt status fields
    localparam int IRQ_AER = 4;
    localparam int IRQ_PME = 5;
    // Link register fields
    localparam int LINK_UP_POS = 5;
    localparam int LINK_LTSSM_POS = 8;
    // Error log fields
    localparam int ERR_RX_PAR = 0;
    localparam int ERR_TX_PAR = 1;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/psr_stretch.sv]
// Pulse stretcher for the four ECC error flags
`timescale 1ns/100ps
`default_nettype none
module psr_stretch (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // One-cycle events in, stretched levels out
    input wire logic [3:0] pulse_in,
    output logic [3:0] stretched_out
);
    import psr_pkg::*;

    logic [2:0] cnt [4]; // Remaining hold cycles per flag

    // Each new event restarts its own hold window
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (!nrst_in) begin
                cnt[i] <= 3'h0;
                stretched_out[i] <= 1'b0;
            end else if (pulse_in[i]) begin
                cnt[i] <= 3'(STRETCH_CYC - 1);
                stretched_out[i] <= 1'b1;
            end else if (cnt[i] != 3'h0) begin
                cnt[i] <= cnt[i] - 3'h1;
                stretched_out[i] <= 1'b1;
            end else begin
                stretched_out[i] <= 1'b0;
            end
        end
    end

    // A lone event must hold the flag for the full window
    chk_ecc_stretch_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(stretched_out[0]) |-> stretched_out[0] [*4])
        else $error("stretched flag dropped early");
endmodule
`default_nettype wire

// [rtl/psr_cfg_mem.sv]
// Byte memory holding the rewritten configuration values
`timescale 1ns/100ps
`default_nettype none
module psr_cfg_mem (
    // Clock
    input wire logic clk_in,
    // Write port
    input wire logic we_in,
    input wire logic [psr_pkg::MEM_AW-1:0] waddr_in,
    input wire logic [7:0] wdata_in,
    // Read port, data registered
    input wire logic [psr_pkg::MEM_AW-1:0] raddr_in,
    output logic [7:0] rdata_out
);
    import psr_pkg::*;

    logic [7:0] mem [2**MEM_AW]; // No reset: cleared by a sweep instead

    // Write port
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    // Read data always comes out of a register
    always_ff @(posedge clk_in) begin
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

// [verif/psr_app_model.sv]
// Application-side requester model for the reconfiguration port
`timescale 1ns/100ps
`default_nettype none
module psr_app_model (
    // Clock
    input wire logic clk_in,
    // Requests toward the port
    output logic [20:0] addr_out,
    output logic read_out,
    output logic write_out,
    output logic [7:0] wdata_out,
    // Answers from the port
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic wait_in
);
    int gap = 0; // Idle cycles added to the one always left before a request, to pace slowly
    // Idle bus at time zero
    initial begin
        addr_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        wdata_out = 8'h00;
    end
    // Offset low, function above, space select on top, rest zero
    function automatic logic [20:0] mk(input logic sp, input logic [1:0] fn, input logic [11:0] o);
        return {sp, 6'h00, fn, o};
    endfunction
    // One byte write, held until wait-request is seen low
    task automatic wr(input logic [1:0] fn, input logic [11:0] o, input logic [7:0] d);
        repeat (gap + 1) @(posedge clk_in);
        addr_out <= mk(1'b1, fn, o);
        wdata_out <= d;
        write_out <= 1'b1;
        do @(posedge clk_in); while (wait_in);
        write_out <= 1'b0;
        addr_out <= ~addr_out; // Released lines must not keep a stale value
        wdata_out <= ~wdata_out;
    endtask
    // One byte read; no new read until the data is back
    task automatic rd(input logic sp, input logic [1:0] fn, input logic [11:0] o,
                      output logic [7:0] d, output int n);
        repeat (gap + 1) @(posedge clk_in);
        addr_out <= mk(sp, fn, o);
        read_out <= 1'b1;
        do @(posedge clk_in); while (wait_in);
        read_out <= 1'b0;
        addr_out <= ~addr_out;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!rvalid_in && n < 8);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// [verif/psr_top_tb_top.sv]
// Self-checking testbench for the status and reconfiguration block
`timescale 1ns/100ps
`default_nettype none
module psr_top_tb_top;
    import psr_pkg::*;
    localparam int CLR = 16; // Short sweep keeps the run brief
    localparam int LIMIT = 5000; // Cycle ceiling against a hang
    // Design inputs, all idle at time zero
    logic clk_in = 1'b0, nrst_in = 1'b0, warm_rst_in = 1'b0;
    logic [3:0] ecc_evt_in = 4'h0, intx_in = 4'h0, fn1_intx_in = 4'h0, fn1_other_in = 4'h0;
    logic root_adv_err_msg_req_in = 1'b0, root_adv_err_wire_req_in = 1'b0;
    logic pme_msg_req_in = 1'b0, pme_wire_req_in = 1'b0, hot_plug_in = 1'b0;
    logic bw_auto_in = 1'b0, bw_mgmt_in = 1'b0, link_eq_req_in = 1'b0, link_up_in = 1'b0;
    logic rx_par_det_in = 1'b0, tx_par_det_in = 1'b0;
    logic [4:0] lane_count_in = 5'h00;
    logic [5:0] ltssm_in = 6'h00;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    // Design outputs and the model's request lines
    logic [3:0] ecc_err_out;
    logic [10:0] int_status_out;
    logic [7:0] irq_state_vec_fn1_out, rcfg_rdata_out;
    logic [2:0] int_common_out;
    logic [4:0] lane_act_out;
    logic [5:0] ltssm_out;
    logic link_up_out, rx_par_err_out, tx_par_err_out, rcfg_rvalid_out, rcfg_wait_out;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rsp;
    logic [31:0] s_rdata, rdat;
    wire logic [20:0] rcfg_addr_in;
    wire logic [7:0] rcfg_wdata_in;
    wire logic rcfg_read_in, rcfg_write_in;
    logic [7:0] rc_data;
    int rc_lat, cycles = 0, miscompares = 0, checked = 0;
    psr_top #(.CLEAR_COUNT(CLR)) u_dut (.*);
    psr_app_model u_app (.clk_in(clk_in), .addr_out(rcfg_addr_in), .read_out(rcfg_read_in),
        .write_out(rcfg_write_in), .wdata_out(rcfg_wdata_in), .rdata_in(rcfg_rdata_out),
        .rvalid_in(rcfg_rvalid_out), .wait_in(rcfg_wait_out));
    always #20 clk_in = ~clk_in;
    // Verdict and end of run
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard counts as a mismatch
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            test_done();
        end
    end
    // Compare one value
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sample just after the n-th edge, once its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Register write; each channel released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask
    // Register read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        tick(1);
        cmp(rcfg_wait_out, 1'b1);
        axi_rd(OFS_CTRL, rdat, rsp);
        cmp(rdat, CTRL_RESET);
        // Each error flag stays up four cycles after a one-cycle event
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in) ecc_evt_in <= 4'h1 << i;
            @(posedge clk_in) ecc_evt_in <= 4'h0;
            #1 cmp(ecc_err_out, 4'h1 << i);
            tick(3);
            cmp(ecc_err_out, 4'h1 << i);
            tick(1);
            cmp(ecc_err_out, 4'h0);
        end
        @(posedge clk_in) begin
            intx_in <= 4'ha;
            hot_plug_in <= 1'b1;
            {link_eq_req_in, bw_mgmt_in, bw_auto_in} <= 3'h5;
        end
        tick(1);
        cmp(int_status_out, 11'h58a);
        cmp(int_common_out, 3'h5);
        axi_wr(OFS_CTRL, 32'h1, rsp); // Power events on, two-function mode
        @(posedge clk_in) {fn1_other_in, fn1_intx_in} <= 8'h96;
        tick(1);
        cmp(int_status_out, 11'h0ca);
        cmp(irq_state_vec_fn1_out, 8'h96);
        @(posedge clk_in) root_adv_err_msg_req_in <= 1'b1;
        @(posedge clk_in) root_adv_err_msg_req_in <= 1'b0;
        @(posedge clk_in) pme_wire_req_in <= 1'b1;
        tick(2);
        cmp(int_status_out[5:4], 2'h3);
        axi_wr(OFS_IRQ, 32'h10, rsp);
        tick(1);
        cmp(int_status_out[5:4], 2'h2);
        @(posedge clk_in) pme_wire_req_in <= 1'b0;
        tick(2);
        cmp(int_status_out[5:4], 2'h0);
        // Wire rise sets bit 4, W1C clears bit 5, wire drop clears bit 4
        @(posedge clk_in) {root_adv_err_wire_req_in, pme_msg_req_in} <= 2'h3;
        @(posedge clk_in) pme_msg_req_in <= 1'b0;
        tick(1);
        cmp(int_status_out[5:4], 2'h3);
        axi_wr(OFS_IRQ, 32'h20, rsp);
        cmp(rsp, RESP_OKAY);
        tick(1);
        cmp(int_status_out[5:4], 2'h1);
        @(posedge clk_in) root_adv_err_wire_req_in <= 1'b0;
        tick(2);
        cmp(int_status_out[5:4], 2'h0);
        // Lane counts 1..16 then an illegal 3
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in) begin
                lane_count_in <= (i < 5) ? 5'h01 << i : 5'h03;
                link_up_in <= i[0];
                ltssm_in <= i[0] ? LTSSM_L0 : LTSSM_HOT_RESET;
            end
            tick(1);
            cmp({ltssm_out, link_up_out, lane_act_out},
                {ltssm_in, link_up_in, (i < 5) ? 5'h01 << i : 5'h00});
        end
        axi_rd(OFS_LINK, rdat, rsp);
        cmp(rdat, 32'h1120);
        @(posedge clk_in) {rx_par_det_in, tx_par_det_in} <= 2'h3;
        tick(1);
        cmp({rx_par_err_out, tx_par_err_out}, 2'h3);
        tick(1);
        cmp({rx_par_err_out, tx_par_err_out}, 2'h0);
        axi_rd(OFS_ERRLOG, rdat, rsp);
        cmp(rdat, 32'h3f);
        axi_wr(OFS_ERRLOG, 32'h3c, rsp);
        axi_rd(OFS_ERRLOG, rdat, rsp);
        cmp(rdat, 32'h03);
        axi_rd(8'h40, rdat, rsp); // Unmapped place
        cmp(rsp, RESP_SLVERR);
        cmp(rdat, 32'h0);
        axi_wr(8'h40, 32'h1, rsp);
        cmp(rsp, RESP_SLVERR);
        // Reconfiguration: writes one idle cycle apart, paced reads, reset loss
        u_app.wr(2'h0, 12'h005, 8'h5a);
        u_app.wr(2'h0, 12'h006, 8'ha5);
        u_app.gap = 2;
        u_app.rd(1'b1, 2'h0, 12'h005, rc_data, rc_lat);
        cmp(rc_data, 8'h5a);
        cmp(rc_lat, 3);
        u_app.rd(1'b0, 2'h0, 12'h006, rc_data, rc_lat);
        cmp(rc_data, 8'h00);
        @(posedge clk_in) warm_rst_in <= 1'b1;
        @(posedge clk_in) warm_rst_in <= 1'b0;
        u_app.rd(1'b1, 2'h0, 12'h006, rc_data, rc_lat);
        cmp(rc_data, 8'h00);
        // Application resets the core after the parity error; writes are lost
        @(posedge clk_in) {nrst_in, rx_par_det_in, tx_par_det_in} <= 3'h0;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        u_app.rd(1'b1, 2'h0, 12'h005, rc_data, rc_lat);
        cmp(rc_data, 8'h00);
        // Four-function mode again: function number on 13:12
        u_app.wr(2'h1, 12'h005, 8'h3c);
        u_app.rd(1'b1, 2'h1, 12'h005, rc_data, rc_lat);
        cmp(rc_data, 8'h3c);
        test_done();
    end
endmodule
`default_nettype wire
